// *** core/counter16_async_access_reset.sv ***
// 16-bit timer/counter with prescaler, compare reset and AHB-Lite registers
//
// Behaviour
// [R01] Count byte reads return a valid, stable value while counting externally.
// [R02] Software reads high, low, high and retries if the high bytes differ.
// [R03] A count write during an increment is undefined; stop the counter first.
// [R04] Control bit 3 starts the crystal oscillator; it runs through sleep.
// [R05] Software waits for oscillator start-up before trusting the count.
// [R06] Compare mode 1011 match resets the count and starts a conversion.
// [R07] Trigger reset works only in timer or synchronised counter mode.
// [R08] A count write in the trigger cycle wins over the trigger reset.
// [R09] With the trigger on, the compare pair acts as the count period.
// [R10] Count bytes survive every reset; only the trigger clears them.
// [R11] Control register clears to zero on power-on reset: stopped, 1:1.
// [R12] Any write to either count byte clears the prescaler.
// [R13] One-second preload: software sets only the high byte MSB.
// [R14] Real-time use needs async mode, overflow enable, oscillator running.
// [R15] Count runs 0000h to FFFFh, rolls over and sets the overflow flag.
// [R16] Prescale field 11,10,01,00 divides by 8, 4, 2 and 1.
// [R17] Sync-disable bypasses the synchroniser; counting continues in sleep. The pins still pass through pin_sync2 in every mode.
// [R18] After enabling counter mode, a falling edge precedes any counting.
// [R19] Read data comes from stable registers, never a partial count.
`timescale 1ns/1ps
module counter16_async_access_reset
   import timer_pkg::*;
(
   // Clock and power-on reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic [31:0] hrdata,
   output      logic        hreadyout,
   output      logic        hresp,
   // Count clock pins and power state
   input  wire logic        ext_clk_pin,
   input  wire logic        crystal_in_pin,
   input  wire logic        sleep_mode,
   input  wire logic        adc_enable,
   // Outputs to the rest of the chip
   output      logic        crystal_osc_enable,
   output      logic        overflow_irq,
   output      logic        special_event_trigger,
   output      logic        adc_start
);

   ////////////////////////////////////////////////////////////////////////
   // State
   logic [CTL_W-1:0]      ctl_reg, ctl_next;
   logic [15:0]           cnt_reg, cnt_next;
   logic [15:0]           cmp_reg, cmp_next;
   logic [CMP_MODE_W-1:0] cmode_reg, cmode_next;
   logic                  ovf_reg, ovf_next;
   logic                  ovf_ie_reg, ovf_ie_next;
   logic [2:0]            pre_reg, pre_next;
   logic                  armed_reg, armed_next;
   logic                  clk_prev_reg, clk_prev_next;
   logic                  trig_reg, trig_next;
   logic                  adc_reg, adc_next;
   logic [31:0]           hrdata_reg, hrdata_next;
   logic                  dph_valid_reg, dph_valid_next;
   logic                  dph_write_reg, dph_write_next;
   logic [7:0]            dph_addr_reg, dph_addr_next;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and edge detection
   logic [1:0] pins_s;
   logic       clk_sel;
   logic       rise;
   logic       fall;

   pin_sync2 #(
      .WIDTH (SYNC_STAGES)
   ) u_pin_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       ({crystal_in_pin, ext_clk_pin}),
      .q       (pins_s)
   );

   logic run;
   logic cs;
   logic sync_dis;
   logic async_mode;
   logic [1:0] ps;

   assign run        = ctl_reg[CTL_RUN_BIT];
   assign cs         = ctl_reg[CTL_CS_BIT];
   assign sync_dis   = ctl_reg[CTL_SYNCDIS_BIT];
   assign ps         = ctl_reg[CTL_PS_MSB:CTL_PS_LSB];
   assign async_mode = cs & sync_dis;

   // Crystal input is the count pin while the oscillator is on
   assign clk_sel = ctl_reg[CTL_OSC_BIT] ? pins_s[1] : pins_s[0];
   assign rise    = clk_sel & ~clk_prev_reg;
   assign fall    = ~clk_sel & clk_prev_reg;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   logic addr_phase;
   logic wr_fire;
   logic wr_low;
   logic wr_high;
   logic cnt_wr;

   assign addr_phase = hsel & htrans[1] & hready;
   assign wr_fire    = dph_valid_reg & dph_write_reg;
   assign wr_low     = wr_fire & (dph_addr_reg == OFS_COUNT_LOW);
   assign wr_high    = wr_fire & (dph_addr_reg == OFS_COUNT_HIGH);
   assign cnt_wr     = wr_low | wr_high;

   ////////////////////////////////////////////////////////////////////////
   // Count path
   logic [2:0]  pre_limit;
   logic        src_pulse;
   logic        pre_go;
   logic        inc;
   logic [15:0] cnt_plus;
   logic        inc_trig;

   // [R16] prescale divider
   always_comb begin
      case (ps)
         PS_DIV1: pre_limit = 3'h0;
         PS_DIV2: pre_limit = 3'h1;
         PS_DIV4: pre_limit = 3'h3;
         PS_DIV8: pre_limit = 3'h7;
         default: pre_limit = 3'h0;
      endcase
   end

   // [R18] counter mode waits for the arming fall
   assign src_pulse = cs ? (armed_reg & rise) : 1'b1;
   // The instruction clock stops in sleep, so timer mode halts there
   assign pre_go    = run & src_pulse & ~(sleep_mode & ~cs);
   // [R17] only async mode (cs with sync-disable) advances the count in sleep
   assign inc       = pre_go & (pre_reg == pre_limit)
                      & ~(sleep_mode & ~async_mode);
   assign cnt_plus  = cnt_reg + 16'h0001;
   // [R07] async mode never sees the compare reset
   assign inc_trig  = inc & (cmode_reg == CMP_SPECIAL) & ~async_mode
                      & (cnt_plus == cmp_reg);

   always_comb begin
      cnt_next      = cnt_reg;
      pre_next      = pre_reg;
      armed_next    = armed_reg;
      clk_prev_next = clk_sel;
      trig_next     = 1'b0;
      adc_next      = 1'b0;
      ovf_next      = ovf_reg;
      if (!run) begin
         armed_next = 1'b0;
      end else if (fall) begin
         armed_next = 1'b1;
      end
      if (pre_go) begin
         pre_next = (pre_reg == pre_limit) ? 3'h0 : pre_reg + 3'h1;
      end
      if (inc) begin
         cnt_next = cnt_plus;
      end
      // [R06] special event resets the count, [R09] period at compare
      if (inc_trig) begin
         cnt_next  = COUNT_ZERO;
         trig_next = 1'b1;
         adc_next  = adc_enable;
      end
      // [R03] [R08] software write beats increment and trigger
      if (wr_low) begin
         cnt_next[7:0] = hwdata[7:0];
      end
      if (wr_high) begin
         cnt_next[15:8] = hwdata[7:0];
      end
      // [R12] count writes restart the prescaler
      if (cnt_wr) begin
         pre_next = 3'h0;
      end
      // Flag clear by write; the hardware set below wins
      if (wr_fire && dph_addr_reg == OFS_STATUS) begin
         ovf_next = hwdata[FLAG_BIT];
      end
      // [R15] rollover sets the overflow flag
      if (inc && cnt_reg == COUNT_TOP) begin
         ovf_next = 1'b1;
      end
   end

   // [R10] count has no reset at all
   always_ff @(posedge hclk) begin
      cnt_reg <= cnt_next;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_reg      <= 3'h0;
         armed_reg    <= 1'b0;
         clk_prev_reg <= 1'b0;
         trig_reg     <= 1'b0;
         adc_reg      <= 1'b0;
         ovf_reg      <= 1'b0;
      end else begin
         pre_reg      <= pre_next;
         armed_reg    <= armed_next;
         clk_prev_reg <= clk_prev_next;
         trig_reg     <= trig_next;
         adc_reg      <= adc_next;
         ovf_reg      <= ovf_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file and bus slave
   always_comb begin
      ctl_next       = ctl_reg;
      cmp_next       = cmp_reg;
      cmode_next     = cmode_reg;
      ovf_ie_next    = ovf_ie_reg;
      dph_valid_next = addr_phase;
      dph_write_next = hwrite;
      dph_addr_next  = haddr[7:0];
      hrdata_next    = hrdata_reg;
      if (wr_fire) begin
         case (dph_addr_reg)
            OFS_CONTROL:    ctl_next = hwdata[CTL_W-1:0];
            OFS_CMP_LOW:    cmp_next[7:0] = hwdata[7:0];
            OFS_CMP_HIGH:   cmp_next[15:8] = hwdata[7:0];
            OFS_CMP_MODE:   cmode_next = hwdata[CMP_MODE_W-1:0];
            OFS_INT_ENABLE: ovf_ie_next = hwdata[FLAG_BIT];
            default:        ctl_next = ctl_reg;
         endcase
      end
      // [R19] read data is latched from settled registers
      if (addr_phase && !hwrite) begin
         case (haddr[7:0])
            // [R01] byte read of the live count
            OFS_COUNT_LOW:  hrdata_next = {24'h000000, cnt_reg[7:0]};
            OFS_COUNT_HIGH: hrdata_next = {24'h000000, cnt_reg[15:8]};
            OFS_CONTROL:    hrdata_next = {26'h0, ctl_reg};
            OFS_CMP_LOW:    hrdata_next = {24'h000000, cmp_reg[7:0]};
            OFS_CMP_HIGH:   hrdata_next = {24'h000000, cmp_reg[15:8]};
            OFS_CMP_MODE:   hrdata_next = {28'h0000000, cmode_reg};
            OFS_STATUS:     hrdata_next = {31'h0, ovf_reg};
            OFS_INT_ENABLE: hrdata_next = {31'h0, ovf_ie_reg};
            default:        hrdata_next = 32'h00000000;
         endcase
      end
   end

   // [R11] power-on reset stops the timer at 1:1
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_reg       <= CTL_RESET;
         cmp_reg       <= CMP_RESET;
         cmode_reg     <= CMP_MODE_RESET;
         ovf_ie_reg    <= 1'b0;
         dph_valid_reg <= 1'b0;
         dph_write_reg <= 1'b0;
         dph_addr_reg  <= 8'h00;
         hrdata_reg    <= 32'h00000000;
      end else begin
         ctl_reg       <= ctl_next;
         cmp_reg       <= cmp_next;
         cmode_reg     <= cmode_next;
         ovf_ie_reg    <= ovf_ie_next;
         dph_valid_reg <= dph_valid_next;
         dph_write_reg <= dph_write_next;
         dph_addr_reg  <= dph_addr_next;
         hrdata_reg    <= hrdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign hrdata    = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   // [R04] oscillator enable straight from the control bit
   assign crystal_osc_enable    = ctl_reg[CTL_OSC_BIT];
   assign overflow_irq          = ovf_reg & ovf_ie_reg;
   assign special_event_trigger = trig_reg;
   assign adc_start             = adc_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_trig_clears_count: assert property ( // [R06]
      @(posedge hclk) disable iff (!hresetn)
      (inc_trig && !cnt_wr) |=> (cnt_reg == COUNT_ZERO) && trig_reg)
      else $error("trigger did not clear the count");

   a_write_beats_trig: assert property ( // [R08]
      @(posedge hclk) disable iff (!hresetn)
      (inc_trig && wr_low) |=> (cnt_reg[7:0] == $past(hwdata[7:0])))
      else $error("trigger overrode a count write");

   a_ovf_on_roll: assert property ( // [R15]
      @(posedge hclk) disable iff (!hresetn)
      (inc && cnt_reg == COUNT_TOP && !cnt_wr && !inc_trig)
      |=> ovf_reg && (cnt_reg == COUNT_ZERO))
      else $error("rollover did not set the flag");

   a_prescale_clear: assert property ( // [R12]
      @(posedge hclk) disable iff (!hresetn)
      cnt_wr |=> (pre_reg == 3'h0))
      else $error("count write left prescaler running");

   a_no_async_trig: assert property ( // [R07]
      @(posedge hclk) disable iff (!hresetn)
      async_mode |=> !trig_reg)
      else $error("trigger fired in async mode");

   a_arm_needs_fall: assert property ( // [R18]
      @(posedge hclk) disable iff (!hresetn)
      (cs && !armed_reg) |-> !inc)
      else $error("counted before the arming edge");

   a_sleep_halts: assert property ( // [R17]
      @(posedge hclk) disable iff (!hresetn)
      (sleep_mode && !async_mode) |-> !inc)
      else $error("synchronised count advanced in sleep");

   a_osc_follows_wr: assert property ( // [R04]
      @(posedge hclk) disable iff (!hresetn)
      (wr_fire && dph_addr_reg == OFS_CONTROL && hwdata[CTL_OSC_BIT])
      |=> crystal_osc_enable)
      else $error("oscillator not enabled by control write");

   a_read_stable: assert property ( // [R19]
      @(posedge hclk) disable iff (!hresetn)
      (addr_phase && !hwrite && haddr[7:0] == OFS_COUNT_HIGH)
      |=> (hrdata == {24'h000000, $past(cnt_reg[15:8])}))
      else $error("count read not taken from register");

   a_ctl_reset: assert property ( // [R11]
      @(posedge hclk) $rose(hresetn) |-> (ctl_reg == CTL_RESET))
      else $error("control register not cleared by reset");

endmodule

// *** core/timer_pkg.sv ***
// Constants shared by the 16-bit timer/counter and its register slave
package timer_pkg;

   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] OFS_COUNT_LOW   = 8'h00;
   localparam logic [7:0] OFS_COUNT_HIGH  = 8'h04;
   localparam logic [7:0] OFS_CONTROL     = 8'h08;
   localparam logic [7:0] OFS_CMP_LOW     = 8'h0c;
   localparam logic [7:0] OFS_CMP_HIGH    = 8'h10;
   localparam logic [7:0] OFS_CMP_MODE    = 8'h14;
   localparam logic [7:0] OFS_STATUS      = 8'h18;
   localparam logic [7:0] OFS_INT_ENABLE  = 8'h1c;

   // Field positions of timer_control_reg
   localparam int CTL_W           = 6;
   localparam int CTL_RUN_BIT     = 0;
   localparam int CTL_CS_BIT      = 1;
   localparam int CTL_SYNCDIS_BIT = 2;
   localparam int CTL_OSC_BIT     = 3;
   localparam int CTL_PS_LSB      = 4;
   localparam int CTL_PS_MSB      = 5;
   localparam logic [CTL_W-1:0] CTL_RESET = 6'h00;

   // Other fields and values
   localparam int FLAG_BIT               = 0;
   localparam int CMP_MODE_W             = 4;
   localparam logic [3:0] CMP_MODE_RESET = 4'h0;
   localparam logic [3:0] CMP_SPECIAL    = 4'hb;
   localparam logic [15:0] CMP_RESET     = 16'hffff;
   localparam logic [15:0] COUNT_TOP     = 16'hffff;
   localparam logic [15:0] COUNT_ZERO    = 16'h0000;
   localparam int SYNC_STAGES            = 2;

   // Prescale field codes
   localparam logic [1:0] PS_DIV1 = 2'h0;
   localparam logic [1:0] PS_DIV2 = 2'h1;
   localparam logic [1:0] PS_DIV4 = 2'h2;
   localparam logic [1:0] PS_DIV8 = 2'h3;

   // AHB transfer types
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// *** core/pin_sync2.sv ***
// Two-flop synchroniser for pin levels entering the hclk domain
`timescale 1ns/1ps
module pin_sync2
   import timer_pkg::*;
#(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // Levels
   input  wire logic [WIDTH-1:0] d,
   output      logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] q_reg;

   // Elaboration check: at least one level to carry
   if (WIDTH < 1) begin : g_width_check
      $error("pin_sync2: WIDTH must be at least 1");
   end

   // First stage is read only by the second stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= '0;
         q_reg    <= '0;
      end else begin
         meta_reg <= d;
         q_reg    <= meta_reg;
      end
   end

   assign q = q_reg;

endmodule

// *** verif/ext_clock_model.sv ***
// Far-side model: external count clock pin and the watch crystal
`timescale 1ns/1ps
module ext_clock_model #(
   parameter int STARTUP = 20
) (
   // Clock and oscillator enable
   input  wire logic hclk,
   input  wire logic osc_on,
   // Pins
   output      logic ext_clk_pin,
   output      logic crystal_in_pin
);
   int up_cnt;
   initial begin
      ext_clk_pin    = 1'b0;
      crystal_in_pin = 1'b0;
      up_cnt         = 0;
   end
   always @(posedge hclk) begin
      up_cnt <= osc_on ? (up_cnt < 99 ? up_cnt + 1 : up_cnt) : 0;
   end
   // Pins rest low between bursts; each level lasts half cycles
   task automatic pulses(input logic xtal, input int n, input int half);
      for (int i = 0; i < 2 * n; i++) begin
         if (!xtal)
            ext_clk_pin <= ~ext_clk_pin;
         else if (up_cnt >= STARTUP)
            crystal_in_pin <= ~crystal_in_pin;
         repeat (half) @(posedge hclk);
      end
   endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the 16-bit timer/counter
`timescale 1ns/1ps
module testbench;
   import timer_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        adc_enable = 1'b1;
   logic        sleep_mode = 1'b0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        ext_clk_pin;
   logic        crystal_in_pin;
   logic        osc_en;
   logic        overflow_irq;
   logic        trig;
   logic        adc_start;
   int          n_fail = 0;
   int          compares = 0;
   int          cyc = 0;
   int          n_trig = 0;
   int          n_adc = 0;
   logic [31:0] d;
   logic [15:0] v;
   logic [15:0] w;

   always #12.5 hclk = ~hclk;

   counter16_async_access_reset u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .ext_clk_pin(ext_clk_pin),
      .crystal_in_pin(crystal_in_pin), .sleep_mode(sleep_mode),
      .adc_enable(adc_enable), .crystal_osc_enable(osc_en),
      .overflow_irq(overflow_irq), .special_event_trigger(trig),
      .adc_start(adc_start)
   );

   ext_clock_model u_far (
      .hclk(hclk), .osc_on(osc_en), .ext_clk_pin(ext_clk_pin),
      .crystal_in_pin(crystal_in_pin)
   );

   ////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("mismatches %0d of %0d compares", n_fail, compares);
      if (n_fail == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Whole run needs about a thousand cycles
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (trig === 1'b1) n_trig <= n_trig + 1;
      if (adc_start === 1'b1) n_adc <= n_adc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   // One single transfer: address phase, then data phase
   task automatic rw(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk(hresp, 1'b0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] x;
      rw(1'b1, a, wd, x);
   endtask

   // high, low, high and retry on a carry
   task automatic rd16(output logic [15:0] r);
      logic [31:0] h1, l, h2;
      rw(1'b0, OFS_COUNT_HIGH, 32'h0, h1);
      rw(1'b0, OFS_COUNT_LOW, 32'h0, l);
      rw(1'b0, OFS_COUNT_HIGH, 32'h0, h2);
      if (h1 !== h2) rw(1'b0, OFS_COUNT_LOW, 32'h0, l);
      r = {h2[7:0], l[7:0]};
   endtask

   // counter is always stopped before the count is written
   task automatic load(input logic [31:0] c, input logic [15:0] cnt);
      wr(OFS_CONTROL, c & ~(32'h1 << CTL_RUN_BIT));
      wr(OFS_COUNT_HIGH, {24'h0, cnt[15:8]});
      wr(OFS_COUNT_LOW, {24'h0, cnt[7:0]});
      wr(OFS_CONTROL, c);
   endtask

   function automatic logic [31:0] ctl(input logic cs, input logic sd,
                                       input logic osc, input int ps);
      return (32'h1 << CTL_RUN_BIT) | (32'(cs) << CTL_CS_BIT)
         | (32'(sd) << CTL_SYNCDIS_BIT) | (32'(osc) << CTL_OSC_BIT)
         | (32'(ps) << CTL_PS_LSB);
   endfunction

   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rw(1'b0, OFS_CONTROL, 32'h0, d);
      chk(d, 32'h0);
      rw(1'b0, OFS_CMP_MODE, 32'h0, d); chk(d, 32'h0);
      rw(1'b0, OFS_CMP_LOW, 32'h0, d); chk(d, {24'h0, CMP_RESET[7:0]});
      wr(8'h20, 32'h5a);
      rw(1'b0, 8'h20, 32'h0, d); chk(d, 32'h0);
      // Nine pulses: the first pulse only arms, eight are counted
      for (int ps = 0; ps < 4; ps++) begin
         load(ctl(1'b1, 1'b0, 1'b0, ps), 16'h0);
         u_far.pulses(1'b0, 9, 4);
         repeat (6) @(posedge hclk);
         wr(OFS_CONTROL, 32'h0);
         rd16(v);
         chk(v, 16'h8 >> ps);
      end
      // A leftover prescale of four must not carry into the next run
      repeat (2) begin
         load(ctl(1'b1, 1'b0, 1'b0, 3), 16'h0);
         u_far.pulses(1'b0, 5, 4);
         repeat (6) @(posedge hclk);
      end
      wr(OFS_CONTROL, 32'h0);
      rd16(v);
      chk(v, 16'h0);
      // Async crystal mode ignores the compare reset and runs in sleep
      wr(OFS_CMP_LOW, 32'h3);
      wr(OFS_CMP_HIGH, 32'h0);
      wr(OFS_CMP_MODE, CMP_SPECIAL);
      wr(OFS_CONTROL, 32'h1 << CTL_OSC_BIT);
      @(posedge hclk);
      chk(osc_en, 1'b1);
      repeat (30) @(posedge hclk);
      load(ctl(1'b1, 1'b1, 1'b1, 0), 16'h0);
      sleep_mode <= 1'b1;
      u_far.pulses(1'b1, 9, 4);
      repeat (6) @(posedge hclk);
      wr(OFS_CONTROL, 32'h1 << CTL_OSC_BIT);
      rd16(v);
      chk(v, 16'h8);
      chk(n_trig, 0);
      // Synchronised counting halts in sleep
      load(ctl(1'b1, 1'b0, 1'b1, 0), 16'h0);
      u_far.pulses(1'b1, 9, 4);
      repeat (6) @(posedge hclk);
      wr(OFS_CONTROL, 32'h0);
      sleep_mode <= 1'b0;
      rd16(v);
      chk(v, 16'h0);
      // Timer mode with the compare pair as period
      wr(OFS_CMP_LOW, 32'h10);
      load(ctl(1'b0, 1'b0, 1'b0, 0), 16'h0);
      for (int i = 0; i < 60 && n_trig == 0; i++) @(posedge hclk);
      wr(OFS_CONTROL, 32'h0);
      chk(n_trig, 1);
      chk(n_adc, 1);
      rd16(v);
      chk(v < 16'h10, 1'b1);
      // Low byte write lands in the trigger cycle, fifteen counts in
      load(ctl(1'b0, 1'b0, 1'b0, 0), 16'h0);
      repeat (14) @(posedge hclk);
      wr(OFS_COUNT_LOW, 32'h80);
      wr(OFS_CONTROL, 32'h0);
      rd16(v);
      chk(v, 16'h0082);
      // Second reset keeps the count and clears the control
      wr(OFS_CONTROL, 32'h38);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd16(w);
      chk(w, v);
      rw(1'b0, OFS_CONTROL, 32'h0, d);
      chk(d, 32'h0);
      chk(osc_en, 1'b0);
      // Rollover sets the flag and the interrupt
      wr(OFS_INT_ENABLE, 32'h1);
      load(ctl(1'b0, 1'b0, 1'b0, 0), 16'hfffd);
      for (int i = 0; i < 20 && overflow_irq !== 1'b1; i++) @(posedge hclk);
      chk(overflow_irq, 1'b1);
      wr(OFS_CONTROL, 32'h0);
      rw(1'b0, OFS_STATUS, 32'h0, d);
      chk(d, 32'h1);
      rd16(v);
      chk(v < 16'h20, 1'b1);
      wr(OFS_STATUS, 32'h0);
      @(posedge hclk);
      chk(overflow_irq, 1'b0);
      // Real-time use: async crystal counting, overflow interrupt on
      wr(OFS_CONTROL, 32'h1 << CTL_OSC_BIT);
      repeat (30) @(posedge hclk);
      load(ctl(1'b1, 1'b1, 1'b1, 0), 16'hfffe);
      u_far.pulses(1'b1, 4, 4);
      repeat (6) @(posedge hclk);
      chk(overflow_irq, 1'b1);
      // Preload by the high byte MSB alone; the low byte keeps counting
      wr(OFS_COUNT_HIGH, 32'h80);
      u_far.pulses(1'b1, 2, 4);
      repeat (6) @(posedge hclk);
      wr(OFS_CONTROL, 32'h0);
      rd16(v);
      chk(v, 16'h8003);
      summarize();
   end
endmodule
